// [core/nfcs_pkg.sv]
// Purpose: Shared constants and types of the NOR flash command sequencer (host side)
// Assumes: 25 MHz system clock, x16 flash with 21 address bits
// Notes: Register offsets are byte addresses on APB; each register is one 32-bit word
package nfcs_pkg;
    // Clock and bus widths
    localparam int CLK_NS = 40;
    localparam int AW = 21;
    localparam int DW = 16;
    localparam int CNT_W = 11;
    // Device timing in ns, turned into cycles (minimums round up, the deadline rounds down)
    localparam int T_RST_NS = 500;
    localparam int T_WAKE_NS = 200;
    localparam int T_WIN_NS = 50000;
    localparam int T_ESUSP_NS = 20000;
    localparam int T_PSUSP_NS = 10000;
    localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC = T_WIN_NS / CLK_NS;
    localparam int ESUSP_CYC = (T_ESUSP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PSUSP_CYC = (T_PSUSP_NS + CLK_NS - 1) / CLK_NS;
    // Command codes
    localparam logic [7:0] C_BYPASS = 8'h20;
    localparam logic [7:0] C_PROG = 8'hA0;
    localparam logic [7:0] C_ESETUP = 8'h80;
    localparam logic [7:0] C_BERASE = 8'h30;
    localparam logic [7:0] C_CERASE = 8'h10;
    localparam logic [7:0] C_BYP_EXIT1 = 8'h90;
    localparam logic [7:0] C_BYP_EXIT2 = 8'h00;
    localparam logic [7:0] C_AUTOSEL = 8'h90;
    localparam logic [7:0] C_RESET = 8'hF0;
    localparam logic [7:0] C_ESUSP = 8'hB0;
    localparam logic [7:0] C_ERES = 8'h30;
    localparam logic [7:0] C_PSUSP = 8'hB0;
    localparam logic [7:0] C_PRES = 8'h30;
    // Unlock cycles
    localparam logic [AW-1:0] UNL1_A = 21'h000555;
    localparam logic [7:0] UNL1_D = 8'hAA;
    localparam logic [AW-1:0] UNL2_A = 21'h0002AA;
    localparam logic [7:0] UNL2_D = 8'h55;
    // Register map
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_ADDR = 12'h004;
    localparam logic [11:0] REG_DATA = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;
    localparam logic [11:0] REG_CTRL = 12'h010;
    // Status and control fields
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_WIN = 3;
    localparam int ST_SUSP = 4;
    localparam int ST_RDATA = 16;
    localparam int CTRL_PROTECT = 0;
    localparam logic [31:0] CTRL_RST = 32'h00000001;
    // Polling bits of the data bus
    localparam int POLL_DONE_BIT = 7;
    localparam int TIMEOUT_FLAG_BIT = 5;

    typedef enum logic [4:0] {
        OP_READ = 5'b00000, OP_PROG = 5'b00001, OP_BYP_ENTER = 5'b00010,
        OP_BYP_PROG = 5'b00011, OP_BYP_BERASE = 5'b00100, OP_BYP_CERASE = 5'b00101,
        OP_BYP_EXIT = 5'b00110, OP_CERASE = 5'b00111, OP_BERASE = 5'b01000,
        OP_ADD_BLOCK = 5'b01001, OP_ESUSP = 5'b01010, OP_ERES = 5'b01011,
        OP_PSUSP = 5'b01100, OP_PRES = 5'b01101, OP_SW_RESET = 5'b01110,
        OP_AUTOSEL = 5'b01111, OP_HW_RESET = 5'b10000, OP_POLL = 5'b10001
    } nfcs_op_t;

    // One bus write cycle: address and data word
    typedef struct packed {
        logic [AW-1:0] a;
        logic [DW-1:0] d;
    } nfcs_cyc_t;

    // Flash pin bundle
    typedef struct packed {
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic rst_b;
        logic protect;
        logic dq_oe_b;
        logic [AW-1:0] addr;
        logic [DW-1:0] dq;
    } nfcs_pins_t;
endpackage

// [core/nfcs_host.sv]
// Purpose: Host controller that issues command sequences to a multi-bank NOR flash
// Assumes: Flash pins sampled synchronously to CLK_SYS; APB slave for software
// Notes: none
// Overview of operation
// - Bypass entry is two unlock cycles then command 20H.
// - Bypass program is exactly A0H then address and data.
// - Bypass erase is 80H-30H for a block, 80H-10H for the chip.
// - Bypass is left only by 90H then 00H.
// - Block erase: unlock, unlock, 80H, unlock, unlock, block address with 30H.
// - Extra blocks with 30H must arrive inside the 50us window.
// - Hardware reset held low at least 500ns; reads valid 200ns after.
// - Hardware reset is held during power-up; release enters read mode.
// - Single cycle F0H ends autoselect.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module nfcs_host import nfcs_pkg::*; #(
    parameter int T_WE_CYC = 2,
    parameter int T_ACC_CYC = 3
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Flash pins
    output logic FL_CE_B,
    output logic FL_OE_B,
    output logic FL_WE_B,
    output logic FL_RESET_B,
    output logic FL_PROTECT_ACCEL,
    output logic [AW-1:0] FL_ADDR,
    input wire logic [DW-1:0] FL_DQ_I,
    output logic [DW-1:0] FL_DQ_O,
    output logic FL_DQ_OE_B
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_WSET = 4'b0001, S_WPUL = 4'b0010, S_WHLD = 4'b0011,
        S_RACC = 4'b0100, S_RGAP = 4'b0101, S_RLOW = 4'b0110, S_RWAKE = 4'b0111,
        S_WAIT = 4'b1000
    } nfcs_state_t;

    // Number of write cycles of each operation
    function automatic logic [2:0] seq_len(input nfcs_op_t op);
        unique case (op)
            OP_PROG: seq_len = 3'd4;
            OP_BYP_ENTER, OP_AUTOSEL: seq_len = 3'd3;
            OP_CERASE, OP_BERASE: seq_len = 3'd6;
            OP_BYP_PROG, OP_BYP_BERASE, OP_BYP_CERASE, OP_BYP_EXIT: seq_len = 3'd2;
            OP_ADD_BLOCK, OP_ESUSP, OP_ERES, OP_PSUSP, OP_PRES, OP_SW_RESET: seq_len = 3'd1;
            default: seq_len = 3'd0;
        endcase
    endfunction

    // Address and data of write cycle idx of an operation
    function automatic nfcs_cyc_t seq_cyc(input nfcs_op_t op, input logic [2:0] idx,
                                          input logic [AW-1:0] a, input logic [DW-1:0] d);
        logic [7:0] c;
        logic full;
        c = 8'h00;
        full = (op == OP_PROG) || (op == OP_BYP_ENTER) || (op == OP_CERASE)
            || (op == OP_BERASE) || (op == OP_AUTOSEL);
        seq_cyc = '{a: a, d: '0};
        if (full && (idx == 3'd0 || (idx == 3'd3 && op != OP_PROG))) begin
            seq_cyc = '{a: UNL1_A, d: {8'h00, UNL1_D}};
        end else if (full && (idx == 3'd1 || idx == 3'd4)) begin
            seq_cyc = '{a: UNL2_A, d: {8'h00, UNL2_D}};
        end else if (full && idx == 3'd2) begin
            unique case (op)
                OP_PROG: c = C_PROG;
                OP_BYP_ENTER: c = C_BYPASS;
                OP_AUTOSEL: c = C_AUTOSEL;
                default: c = C_ESETUP;
            endcase
            seq_cyc = '{a: (op == OP_AUTOSEL) ? a : UNL1_A, d: {8'h00, c}};
        end else begin
            unique case (op)
                OP_PROG: seq_cyc.d = d;
                OP_CERASE: seq_cyc = '{a: UNL1_A, d: {8'h00, C_CERASE}};
                OP_BERASE, OP_ADD_BLOCK: seq_cyc.d = {8'h00, C_BERASE};
                OP_BYP_PROG: seq_cyc.d = (idx == 3'd0) ? {8'h00, C_PROG} : d;
                OP_BYP_BERASE: seq_cyc.d = {8'h00, (idx == 3'd0) ? C_ESETUP : C_BERASE};
                OP_BYP_CERASE: seq_cyc.d = {8'h00, (idx == 3'd0) ? C_ESETUP : C_CERASE};
                OP_BYP_EXIT: seq_cyc.d = {8'h00, (idx == 3'd0) ? C_BYP_EXIT1 : C_BYP_EXIT2};
                OP_ESUSP: seq_cyc.d = {8'h00, C_ESUSP};
                OP_ERES: seq_cyc.d = {8'h00, C_ERES};
                OP_PSUSP: seq_cyc.d = {8'h00, C_PSUSP};
                OP_PRES: seq_cyc.d = {8'h00, C_PRES};
                OP_SW_RESET: seq_cyc.d = {8'h00, C_RESET};
                default: seq_cyc.d = '0;
            endcase
        end
    endfunction

    nfcs_state_t state_q, state_d;
    nfcs_op_t op_q, op_d;
    nfcs_pins_t pins_q, pins_d;
    nfcs_cyc_t cyc, cyc_nx;
    logic [CNT_W-1:0] cnt_q, cnt_d, win_q, win_d;
    logic [2:0] idx_q, idx_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] data_q, data_d, rdata_q, rdata_d;
    logic [31:0] ctrl_q, ctrl_d, prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic refused_q, refused_d, fail_q, fail_d, susp_q, susp_d;
    logic acc, wr_go, cmd_wr, start, win_open;
    nfcs_op_t new_op;

    assign acc = PSEL && PENABLE;
    assign wr_go = acc && pready_q && PWRITE;
    assign cmd_wr = wr_go && (PADDR == REG_CMD);
    assign new_op = nfcs_op_t'(PWDATA[4:0]);
    assign win_open = (win_q != '0);
    // Late extra blocks and unknown codes are refused rather than sent
    assign start = cmd_wr && (state_q == S_IDLE) && new_op <= OP_POLL
        && !(new_op == OP_ADD_BLOCK && !win_open);

    // APB register file: one wait state, answer registered
    always_comb begin
        pready_d = acc && !pready_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        addr_d = addr_q;
        data_d = data_q;
        ctrl_d = ctrl_q;
        refused_d = refused_q;
        if (acc && !pready_q) begin
            prdata_d = '0;
            unique case (PADDR)
                REG_CMD: prdata_d = {27'h0, op_q};
                REG_ADDR: prdata_d = {11'h0, addr_q};
                REG_DATA: prdata_d = {16'h0, data_q};
                REG_CTRL: prdata_d = ctrl_q;
                REG_STAT: begin
                    prdata_d[ST_RDATA +: DW] = rdata_q;
                    prdata_d[ST_BUSY] = (state_q != S_IDLE);
                    prdata_d[ST_REFUSED] = refused_q;
                    prdata_d[ST_FAIL] = fail_q;
                    prdata_d[ST_WIN] = win_open;
                    prdata_d[ST_SUSP] = susp_q;
                end
                default: pslverr_d = 1'b1;
            endcase
        end
        if (wr_go) begin
            unique case (PADDR)
                REG_ADDR: addr_d = PWDATA[AW-1:0];
                REG_DATA: data_d = PWDATA[DW-1:0];
                REG_CTRL: ctrl_d = {31'h0, PWDATA[CTRL_PROTECT]};
                REG_STAT: if (PWDATA[ST_REFUSED]) refused_d = 1'b0;
                default: ;
            endcase
        end
        // A refusal in the clearing cycle still sticks
        if (cmd_wr && !start) begin
            refused_d = 1'b1;
        end
    end

    // APB registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            ctrl_q <= CTRL_RST;
            refused_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
            addr_q <= addr_d;
            data_q <= data_d;
            ctrl_q <= ctrl_d;
            refused_q <= refused_d;
        end
    end

    // Sequencer: builds each write cycle as setup, enable pulse, hold
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        rdata_d = rdata_q;
        fail_d = fail_q;
        susp_d = susp_q;
        pins_d = pins_q;
        pins_d.protect = ctrl_q[CTRL_PROTECT];
        win_d = win_open ? win_q - 1'b1 : win_q;
        cyc = seq_cyc(op_q, idx_q, addr_q, data_q);
        cyc_nx = seq_cyc(start ? new_op : op_q, start ? '0 : idx_q + 3'd1, addr_q, data_q);
        unique case (state_q)
            S_IDLE: if (start) begin
                op_d = new_op;
                idx_d = '0;
                fail_d = 1'b0;
                // Anything but another block drops the queued erase, a suspend included
                if (new_op != OP_ADD_BLOCK) win_d = '0;
                if (new_op == OP_READ || new_op == OP_POLL) begin
                    pins_d.ce_b = 1'b0;
                    pins_d.oe_b = 1'b0;
                    pins_d.addr = addr_q;
                    cnt_d = CNT_W'(T_ACC_CYC - 1);
                    state_d = S_RACC;
                end else if (new_op == OP_HW_RESET) begin
                    pins_d.rst_b = 1'b0;
                    pins_d.ce_b = 1'b1;
                    cnt_d = CNT_W'(RST_CYC - 1);
                    state_d = S_RLOW;
                end else begin
                    // Address set before WE falls so the later falling edge carries it
                    pins_d.ce_b = 1'b0;
                    pins_d.addr = cyc_nx.a;
                    state_d = S_WSET;
                end
            end
            S_WSET: begin
                pins_d.we_b = 1'b0;
                pins_d.dq_oe_b = 1'b0;
                pins_d.dq = cyc.d;
                cnt_d = CNT_W'(T_WE_CYC - 1);
                state_d = S_WPUL;
            end
            S_WPUL: if (cnt_q == '0) begin
                pins_d.we_b = 1'b1;
                state_d = S_WHLD;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
            S_WHLD: begin
                pins_d.ce_b = 1'b1;
                pins_d.dq_oe_b = 1'b1;
                if (idx_q + 3'd1 >= seq_len(op_q)) begin
                    state_d = S_IDLE;
                    unique case (op_q)
                        OP_BERASE, OP_BYP_BERASE, OP_ADD_BLOCK: win_d = CNT_W'(WIN_CYC);
                        OP_ESUSP: begin
                            susp_d = 1'b1;
                            cnt_d = CNT_W'(ESUSP_CYC - 1);
                            state_d = S_WAIT;
                        end
                        OP_PSUSP: begin
                            cnt_d = CNT_W'(PSUSP_CYC - 1);
                            state_d = S_WAIT;
                        end
                        OP_ERES: susp_d = 1'b0;
                        default: ;
                    endcase
                end else begin
                    idx_d = idx_q + 3'd1;
                    pins_d.ce_b = 1'b0;
                    pins_d.addr = cyc_nx.a;
                    state_d = S_WSET;
                end
            end
            S_RACC: if (cnt_q == '0) begin
                rdata_d = FL_DQ_I;
                pins_d.ce_b = 1'b1;
                pins_d.oe_b = 1'b1;
                state_d = S_RGAP;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
            S_RGAP: begin
                state_d = S_IDLE;
                // Poll until the done bit matches the written data or the timeout flag shows
                if (op_q == OP_POLL && rdata_q[POLL_DONE_BIT] != data_q[POLL_DONE_BIT]) begin
                    if (rdata_q[TIMEOUT_FLAG_BIT]) begin
                        fail_d = 1'b1;
                    end else begin
                        pins_d.ce_b = 1'b0;
                        pins_d.oe_b = 1'b0;
                        cnt_d = CNT_W'(T_ACC_CYC - 1);
                        state_d = S_RACC;
                    end
                end
            end
            S_RLOW: if (cnt_q == '0) begin
                pins_d.rst_b = 1'b1;
                cnt_d = CNT_W'(WAKE_CYC - 1);
                win_d = '0;
                susp_d = 1'b0;
                state_d = S_RWAKE;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
            S_RWAKE, S_WAIT: if (cnt_q == '0) begin
                state_d = S_IDLE;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
            default: state_d = S_IDLE;
        endcase
    end

    // Sequencer registers; reset holds the flash reset low as at power-up
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= S_RLOW;
            op_q <= OP_HW_RESET;
            cnt_q <= CNT_W'(RST_CYC - 1);
            idx_q <= '0;
            win_q <= '0;
            rdata_q <= '0;
            fail_q <= 1'b0;
            susp_q <= 1'b0;
            pins_q <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, rst_b: 1'b0, protect: 1'b1,
                        dq_oe_b: 1'b1, addr: '0, dq: '0};
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            win_q <= win_d;
            rdata_q <= rdata_d;
            fail_q <= fail_d;
            susp_q <= susp_d;
            pins_q <= pins_d;
        end
    end

    // Outputs straight from flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign FL_CE_B = pins_q.ce_b;
    assign FL_OE_B = pins_q.oe_b;
    assign FL_WE_B = pins_q.we_b;
    assign FL_RESET_B = pins_q.rst_b;
    assign FL_PROTECT_ACCEL = pins_q.protect;
    assign FL_ADDR = pins_q.addr;
    assign FL_DQ_O = pins_q.dq;
    assign FL_DQ_OE_B = pins_q.dq_oe_b;
endmodule // nfcs_host

// [tb/nfcs_host_sva.sv]
// Purpose: Port checker of the NOR flash host
// Assumes: One clock domain; reset count compared against a package figure, strobe count against T_WE_CYC
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module nfcs_host_sva import nfcs_pkg::*; #(
    parameter int T_WE_CYC = 2
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Flash pins
    input wire logic FL_CE_B,
    input wire logic FL_OE_B,
    input wire logic FL_WE_B,
    input wire logic FL_RESET_B,
    input wire logic FL_PROTECT_ACCEL,
    input wire logic [AW-1:0] FL_ADDR,
    input wire logic [DW-1:0] FL_DQ_O,
    input wire logic FL_DQ_OE_B
);
    logic [7:0] low_q, low_d, we_q, we_d;
    // Run lengths of the low phases; saturate so a long stall never wraps
    always_comb begin
        low_d = FL_RESET_B ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
        we_d = FL_WE_B ? 8'h00 : we_q + {7'h00, we_q != 8'hFF};
    end
    // Counter registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            low_q <= 8'h00;
            we_q <= 8'h00;
        end else begin
            low_q <= low_d;
            we_q <= we_d;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_answer; PSEL && PENABLE && !PREADY ##1 PSEL && PENABLE && PREADY; endsequence
    sequence s_strobe_end; !FL_CE_B && we_q == T_WE_CYC ##1 FL_DQ_OE_B; endsequence
    property p_apb_wait; s_setup |=> s_answer; endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("answer not after one wait state");
    property p_ready_pulse; PREADY |=> !PREADY; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_slverr; PSLVERR |-> PREADY; endproperty
    a_slverr: assert property (p_slverr) else $error("error without ready");
    property p_strobe; $fell(FL_WE_B) |-> !FL_CE_B && FL_OE_B && !FL_DQ_OE_B; endproperty
    a_strobe: assert property (p_strobe) else $error("write strobe without select");
    property p_we_len; $rose(FL_WE_B) |-> s_strobe_end; endproperty
    a_we_len: assert property (p_we_len) else $error("write strobe length or order");
    property p_hold; !FL_WE_B && !$past(FL_WE_B) |-> $stable(FL_DQ_O) && $stable(FL_ADDR); endproperty
    a_hold: assert property (p_hold) else $error("address or data moved in strobe");
    property p_rst_len; $rose(FL_RESET_B) |-> low_q >= RST_CYC; endproperty
    a_rst_len: assert property (p_rst_len) else $error("flash reset pulse short");
    property p_wake; $rose(FL_RESET_B) |-> FL_CE_B [*5]; endproperty
    a_wake: assert property (p_wake) else $error("access inside wake time");
    property p_quiet; !FL_RESET_B |-> FL_CE_B && FL_WE_B && FL_DQ_OE_B; endproperty
    a_quiet: assert property (p_quiet) else $error("bus active during flash reset");
    property p_protect; PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_CTRL
        |-> ##2 FL_PROTECT_ACCEL == $past(PWDATA[CTRL_PROTECT], 2); endproperty
    a_protect: assert property (p_protect) else $error("protect pin not following");
endmodule // nfcs_host_sva

// [tb/nfcs_flash_model.sv]
// Purpose: Behavioural NOR flash for the host bench
// Assumes: One array word stands for the whole array
// Notes: fail_mode is set by the bench to force a timed-out program
`timescale 1ns/1ps
module nfcs_flash_model import nfcs_pkg::*; #(
    parameter int BUSY_NS = 2000
) (
    // Pins from the host
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic rst_b,
    input wire logic protect,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] dq_i,
    // Read data
    output logic [DW-1:0] dq_o
);
    logic [AW-1:0] a_q = '0;
    logic [DW-1:0] mem_d = 16'hFFFF;
    logic [DW-1:0] rd_q = '0;
    logic [DW-1:0] last_d = '0;
    logic pset = 1'b0;
    logic eset = 1'b0;
    logic failed = 1'b0;
    logic fail_mode = 1'b0;
    int wr_cnt = 0;
    realtime busy_until = 0;
    // Address on the later falling edge
    always @(negedge we_b) if (!ce_b) a_q = addr;
    // Data on the earlier rising edge; only defined patterns act, the rest are still counted in wr_cnt and kept in last_d
    always @(posedge we_b) begin
        logic [7:0] c;
        logic boot;
        c = dq_i[7:0];
        boot = (a_q[20:13] == 8'h00) || (&a_q[20:13]);
        if (!ce_b && rst_b) begin
            wr_cnt++;
            last_d = dq_i;
            if (pset && !(boot && !protect)) begin
                mem_d = dq_i;
                busy_until = $realtime + (fail_mode ? 0 : BUSY_NS);
                failed = fail_mode;
            end else if (eset && (c == C_CERASE || c == C_BERASE)) begin
                mem_d = 16'hFFFF;
                busy_until = $realtime + BUSY_NS;
            end else if (c == C_RESET && $realtime >= busy_until) begin
                failed = 1'b0;
            end
            pset = !pset && c == C_PROG;
            eset = c == C_ESETUP || (eset && (c == UNL1_D || c == UNL2_D));
        end
    end
    // Status while busy: poll bit inverted, timeout bit on a failed program
    always @(negedge oe_b) begin
        if (failed || $realtime < busy_until) begin
            rd_q = {8'h00, ~mem_d[POLL_DONE_BIT], 1'b0, failed, 5'h00};
        end else begin
            rd_q = mem_d;
        end
    end
    // Hardware reset aborts whatever runs
    always @(negedge rst_b) begin
        busy_until = 0;
        failed = 1'b0;
        pset = 1'b0;
        eset = 1'b0;
    end
    // Released bus shows the inverse, so a stale sample cannot pass
    assign dq_o = (!ce_b && !oe_b && rst_b) ? rd_q : ~rd_q;
endmodule // nfcs_flash_model

// [tb/nfcs_host_tb.sv]
// Purpose: Self-checking bench of the NOR flash host
// Assumes: APB master below; flash model answers on its pins
// Notes: Sequences are judged by the cycles the model latched
`timescale 1ns/1ps
module nfcs_host_tb import nfcs_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic fl_ce_b, fl_oe_b, fl_we_b, fl_reset_b, fl_protect, fl_dq_oe_b;
    logic [AW-1:0] fl_addr;
    logic [DW-1:0] fl_dq_o, m_dq, dq_bus;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int n0;
    nfcs_op_t t_op [15] = '{OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_BERASE, OP_BYP_CERASE, OP_BYP_EXIT, OP_PROG,
        OP_CERASE, OP_BERASE, OP_ADD_BLOCK, OP_ESUSP, OP_ERES, OP_PSUSP, OP_PRES, OP_AUTOSEL, OP_SW_RESET};
    int t_n [15] = '{3, 2, 2, 2, 2, 4, 6, 6, 1, 1, 1, 1, 1, 3, 1};
    logic [15:0] t_d [15] = '{16'h0020, 16'h5A3C, 16'h0030, 16'h0010, 16'h0000, 16'h5A3C, 16'h0010,
        16'h0030, 16'h0030, 16'h00B0, 16'h0030, 16'h00B0, 16'h0030, 16'h0090, 16'h00F0};
    // Clock and shared data wire
    always #20 clk_sys = ~clk_sys;
    assign dq_bus = !fl_dq_oe_b ? fl_dq_o : m_dq;
    nfcs_host u_nfcs_host (.CLK_SYS(clk_sys), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FL_CE_B(fl_ce_b),
        .FL_OE_B(fl_oe_b), .FL_WE_B(fl_we_b), .FL_RESET_B(fl_reset_b), .FL_PROTECT_ACCEL(fl_protect),
        .FL_ADDR(fl_addr), .FL_DQ_I(dq_bus), .FL_DQ_O(fl_dq_o), .FL_DQ_OE_B(fl_dq_oe_b));
    nfcs_flash_model u_nfcs_flash_model (.ce_b(fl_ce_b), .oe_b(fl_oe_b), .we_b(fl_we_b), .rst_b(fl_reset_b),
        .protect(fl_protect), .addr(fl_addr), .dq_i(dq_bus), .dq_o(m_dq));
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request holds until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Start an operation and poll status until it is no longer busy
    task automatic run_op(input nfcs_op_t op);
        apb(1'b1, REG_CMD, {27'h0, op});
        do apb(1'b0, REG_STAT, 32'h00000000); while (rd[ST_BUSY] !== 1'b0);
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        check(fl_reset_b, 1'b0);
        run_op(OP_READ);
        check(rd[ST_REFUSED], 1'b1);
        apb(1'b1, REG_STAT, 32'h00000002);
        apb(1'b0, REG_STAT, 32'h00000000);
        check(rd[ST_REFUSED], 1'b0);
        apb(1'b0, REG_CTRL, 32'h00000000);
        check(rd, CTRL_RST);
        apb(1'b0, 12'h020, 32'h00000000);
        check(err, 1'b1);
        apb(1'b1, REG_ADDR, 32'h00012345);
        apb(1'b1, REG_DATA, 32'h00005A3C);
        for (int i = 0; i < 15; i++) begin
            n0 = u_nfcs_flash_model.wr_cnt;
            run_op(t_op[i]);
            check(u_nfcs_flash_model.wr_cnt - n0, t_n[i]);
            check(u_nfcs_flash_model.last_d, t_d[i]);
            if (t_op[i] == OP_PROG) check(u_nfcs_flash_model.a_q, 32'h00012345);
            if (t_op[i] == OP_BERASE) check(rd[ST_WIN], 1'b1);
            if (t_op[i] == OP_ESUSP) check(rd[ST_SUSP], 1'b1);
        end
        n0 = u_nfcs_flash_model.wr_cnt;
        run_op(nfcs_op_t'(5'd20));
        run_op(OP_ADD_BLOCK);
        check(rd[ST_REFUSED], 1'b1);
        check(u_nfcs_flash_model.wr_cnt, n0);
        apb(1'b1, REG_STAT, 32'h00000002);
        run_op(OP_PROG);
        run_op(OP_POLL);
        check(rd[ST_FAIL], 1'b0);
        check(rd[31:16], 16'h5A3C);
        u_nfcs_flash_model.fail_mode = 1'b1;
        apb(1'b1, REG_DATA, 32'h000000A5);
        run_op(OP_PROG);
        run_op(OP_POLL);
        check(rd[ST_FAIL], 1'b1);
        u_nfcs_flash_model.fail_mode = 1'b0;
        run_op(OP_SW_RESET);
        run_op(OP_READ);
        check(rd[31:16], 16'h00A5);
        apb(1'b1, REG_CTRL, 32'h00000000);
        apb(1'b1, REG_ADDR, 32'h00000100);
        apb(1'b1, REG_DATA, 32'h00001111);
        run_op(OP_PROG);
        run_op(OP_READ);
        check(rd[31:16], 16'h00A5);
        apb(1'b1, REG_CTRL, CTRL_RST);
        run_op(OP_PROG);
        run_op(OP_POLL);
        check(rd[31:16], 16'h1111);
        run_op(OP_HW_RESET);
        check(fl_reset_b, 1'b1);
        complete_run();
    end
endmodule // nfcs_host_tb
bind nfcs_host nfcs_host_sva #(.T_WE_CYC(T_WE_CYC)) u_nfcs_host_sva (.CLK_SYS(CLK_SYS), .RST_B(RST_B),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FL_CE_B(FL_CE_B), .FL_OE_B(FL_OE_B), .FL_WE_B(FL_WE_B), .FL_RESET_B(FL_RESET_B),
    .FL_PROTECT_ACCEL(FL_PROTECT_ACCEL), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_B(FL_DQ_OE_B));
